// ==== hw/contact_moisture_detector.sv ====
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module contact_moisture_detector
  import moist_pkg::*;
#(
  parameter longint AUTO_HALF_CYCLES = HALF_STEP_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog front end
  output logic meas_active,
  output logic meas_channel,
  output logic [1:0] pullup_code,
  input wire logic adc_valid,
  input wire logic [7:0] adc_data,
  // Status
  output logic [1:0] moisture_found,
  output logic irq
);

  // Bus phase state
  logic wr_ph_q;
  logic rd_ph_q;
  logic rd_done_q;
  logic [7:0] idx_q;
  logic [31:0] hrdata_q;
  // Software registers
  logic [5:0] noise_margin_q;
  logic [1:0] target_current_sel_q;
  logic [7:0] moisture_vthresh_q;
  logic [1:0] auto_en_q;
  logic [1:0] man_check_q;
  logic [1:0] man_retry_q;
  logic [1:0] auto_rearm_q;
  logic [2:0] sample_count_sel_q;
  logic [2:0] measure_retry_count_q;
  logic [EV_W-1:0] irq_stat_q;
  logic [EV_W-1:0] irq_mask_q;
  // Results
  logic [1:0] final_current_code_q;
  logic [7:0] reading_average_q;
  logic [7:0] reading_maximum_q;
  logic [7:0] reading_minimum_q;
  logic [1:0] wet_q;
  // Scheduler
  logic [31:0] tick_cnt_q;
  logic tick_phase_q;
  logic [1:0] auto_pend_q;
  // Sequencer
  meas_state_t st_q;
  logic ch_q;
  logic [1:0] code_q;
  logic [7:0] nsamp_q;
  logic [14:0] sum_q;
  logic [7:0] smax_q;
  logic [7:0] smin_q;
  logic [2:0] tries_q;
  // Combinational helpers
  logic addr_ok;
  logic wr_ctrl;
  logic tick;
  logic [1:0] req;
  logic [7:0] samples_needed;
  logic [7:0] avg_w;
  logic [7:0] clamp_lvl;
  logic sat;
  logic open_res;
  logic short_res;
  logic done;
  logic abort_res;
  logic [EV_W-1:0] ev;

  // Address phase acceptance
  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = !(rd_ph_q && !rd_done_q);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wr_ctrl = wr_ph_q && (idx_q == IDX_CONTROL);

  // Capture address phase; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      rd_done_q <= 1'b0;
      idx_q <= 8'h00;
    end else begin
      if (hreadyout) begin
        wr_ph_q <= addr_ok && hwrite;
        rd_ph_q <= addr_ok && !hwrite;
        rd_done_q <= 1'b0;
        if (addr_ok) begin
          idx_q <= (haddr[1:0] == 2'b00) ? haddr[9:2] : 8'hFF;
        end
      end else begin
        rd_done_q <= 1'b1;
      end
    end
  end

  // Read data mux, unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_ph_q && !rd_done_q) begin
      unique case (idx_q)
        IDX_RETRY_CTRL: hrdata_q <= {29'h0, measure_retry_count_q};
        IDX_AVG_CTRL: hrdata_q <= {29'h0, sample_count_sel_q};
        IDX_NOISE: hrdata_q <= {26'h0, noise_margin_q};
        IDX_CUR_SEL: hrdata_q <= {30'h0, target_current_sel_q};
        IDX_VTHRESH: hrdata_q <= {24'h0, moisture_vthresh_q};
        IDX_CONTROL: hrdata_q <= {24'h0, auto_en_q, man_check_q, man_retry_q, auto_rearm_q};
        IDX_FIN_CUR: hrdata_q <= {30'h0, final_current_code_q};
        IDX_AVG: hrdata_q <= {24'h0, reading_average_q};
        IDX_MAX: hrdata_q <= {24'h0, reading_maximum_q};
        IDX_MIN: hrdata_q <= {24'h0, reading_minimum_q};
        IDX_IRQ_STAT: hrdata_q <= {28'h0, irq_stat_q};
        IDX_IRQ_MASK: hrdata_q <= {28'h0, irq_mask_q};
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Plain configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      noise_margin_q <= RST_NOISE;
      target_current_sel_q <= RST_CUR_SEL;
      moisture_vthresh_q <= RST_VTHRESH;
      auto_en_q <= 2'b00;
      auto_rearm_q <= RST_REARM;
      sample_count_sel_q <= RST_AVG_SEL;
      measure_retry_count_q <= RST_RETRY;
      irq_mask_q <= '0;
    end else if (wr_ph_q) begin
      unique case (idx_q)
        IDX_RETRY_CTRL: measure_retry_count_q <= hwdata[2:0];
        IDX_AVG_CTRL: sample_count_sel_q <= hwdata[2:0];
        IDX_NOISE: noise_margin_q <= hwdata[5:0];
        IDX_CUR_SEL: target_current_sel_q <= hwdata[1:0];
        IDX_VTHRESH: moisture_vthresh_q <= hwdata[7:0];
        IDX_CONTROL: begin
          auto_en_q <= hwdata[POS_AUTO_EN+:2];
          auto_rearm_q <= hwdata[POS_REARM+:2];
        end
        IDX_IRQ_MASK: irq_mask_q <= hwdata[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Manual request bits: set by a one (retry bits only on a wet channel), cleared at completion; a new write wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      man_check_q <= 2'b00;
      man_retry_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_ctrl && hwdata[POS_MAN_CHECK+i]) begin
          man_check_q[i] <= 1'b1;
        end else if (done && (ch_q == i[0])) begin
          man_check_q[i] <= 1'b0;
        end
        if (wr_ctrl && hwdata[POS_MAN_RETRY+i] && wet_q[i]) begin
          man_retry_q[i] <= 1'b1;
        end else if (done && (ch_q == i[0])) begin
          man_retry_q[i] <= 1'b0;
        end
      end
    end
  end

  // Eight-second step timer; odd steps serve channel one, even steps channel two
  assign tick = (tick_cnt_q == 32'(AUTO_HALF_CYCLES - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_phase_q <= 1'b0;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_phase_q <= !tick_phase_q;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // Automatic requests: enabled checks, or re-arm checks while moisture stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_pend_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (tick && (tick_phase_q == i[0]) && (auto_en_q[i] || (auto_rearm_q[i] && wet_q[i]))) begin
          auto_pend_q[i] <= 1'b1;
        end else if (done && (ch_q == i[0])) begin
          auto_pend_q[i] <= 1'b0;
        end
      end
    end
  end

  assign req = man_check_q | man_retry_q | auto_pend_q;
  assign samples_needed = 8'(9'h001 << sample_count_sel_q);
  // Average is the sum shifted by the sample count code
  assign avg_w = 8'(sum_q >> sample_count_sel_q);
  assign clamp_lvl = READ_FULL - {2'b00, noise_margin_q};
  assign sat = (smax_q == READ_FULL) && ((code_q != 2'b00) || (avg_w < clamp_lvl));
  assign open_res = (smax_q == READ_FULL) && !sat;
  assign short_res = (smax_q == READ_LOW);
  assign done = (st_q == ST_JUDGE) && !(sat && (tries_q != 3'h0));
  assign abort_res = sat;

  // Measurement sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_IDLE;
      ch_q <= 1'b0;
      code_q <= 2'b00;
      nsamp_q <= 8'h00;
      sum_q <= 15'h0000;
      smax_q <= 8'h00;
      smin_q <= 8'hFF;
      tries_q <= 3'h0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          nsamp_q <= 8'h00;
          sum_q <= 15'h0000;
          smax_q <= 8'h00;
          smin_q <= 8'hFF;
          if (req != 2'b00) begin
            st_q <= ST_SAMPLE;
            ch_q <= !req[0];
            code_q <= target_current_sel_q;
            tries_q <= measure_retry_count_q;
          end
        end
        ST_SAMPLE: begin
          if (adc_valid) begin
            nsamp_q <= nsamp_q + 8'h01;
            sum_q <= sum_q + {7'h00, adc_data};
            if (adc_data > smax_q) begin
              smax_q <= adc_data;
            end
            if (adc_data < smin_q) begin
              smin_q <= adc_data;
            end
            if (nsamp_q == samples_needed - 8'h01) begin
              st_q <= ST_JUDGE;
            end
          end
        end
        ST_JUDGE: begin
          nsamp_q <= 8'h00;
          sum_q <= 15'h0000;
          smax_q <= 8'h00;
          smin_q <= 8'hFF;
          if (done) begin
            st_q <= ST_IDLE;
          end else begin
            st_q <= ST_SAMPLE;
            tries_q <= tries_q - 3'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Result registers change only when a measurement completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      final_current_code_q <= 2'b00;
      reading_average_q <= 8'h00;
      reading_maximum_q <= 8'h00;
      reading_minimum_q <= 8'h00;
    end else if (done) begin
      if (abort_res || open_res) begin
        final_current_code_q <= CUR_FORCE_LOW;
      end else if (short_res) begin
        final_current_code_q <= CUR_FORCE_SHORT;
      end else begin
        final_current_code_q <= code_q;
      end
      if (abort_res || short_res) begin
        reading_average_q <= READ_LOW;
        reading_maximum_q <= READ_LOW;
        reading_minimum_q <= READ_LOW;
      end else if (open_res) begin
        reading_average_q <= READ_FULL;
        reading_maximum_q <= READ_FULL;
        reading_minimum_q <= READ_FULL;
      end else begin
        reading_average_q <= avg_w;
        reading_maximum_q <= smax_q;
        reading_minimum_q <= smin_q;
      end
    end
  end

  // Moisture flag per channel; a wet result re-arms the channel, a dry one clears the flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wet_q <= 2'b00;
    end else if (done && !abort_res) begin
      wet_q[ch_q] <= !open_res && !short_res && (avg_w < moisture_vthresh_q);
    end
  end

  // Interrupt status, write one to clear, a new event wins
  assign ev[EV_DONE] = done;
  assign ev[EV_WET1] = done && !ch_q && !abort_res && !open_res && !short_res
    && (avg_w < moisture_vthresh_q);
  assign ev[EV_WET2] = done && ch_q && !abort_res && !open_res && !short_res
    && (avg_w < moisture_vthresh_q);
  assign ev[EV_ABORT] = done && abort_res;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
    end else if (wr_ph_q && (idx_q == IDX_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~hwdata[EV_W-1:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  // Outputs to the front end and system
  assign meas_active = (st_q != ST_IDLE);
  assign meas_channel = ch_q;
  assign pullup_code = code_q;
  assign moisture_found = wet_q;
  assign irq = |(irq_stat_q & irq_mask_q);

  // Checks
  AST_READ_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_ok && !hwrite && hreadyout) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_CUR_START: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_IDLE && req != 2'b00) |=> pullup_code == $past(target_current_sel_q))
    else $error("pull-up code not taken from select");
  AST_OPEN_FORCE: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && open_res) |=> final_current_code_q == CUR_FORCE_LOW && reading_average_q == READ_FULL)
    else $error("open result not forced");
  AST_SHORT_FORCE: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && short_res && !abort_res) |=> final_current_code_q == CUR_FORCE_SHORT
    && reading_maximum_q == READ_LOW && reading_minimum_q == READ_LOW)
    else $error("short result not forced");
  AST_ABORT_FORCE: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && abort_res) |=> reading_average_q == READ_LOW && irq_stat_q[EV_ABORT])
    else $error("abort not reported");
  AST_MAN_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && !ch_q && !(wr_ctrl && hwdata[POS_MAN_CHECK])) |=> !man_check_q[0])
    else $error("manual check bit not cleared");
  AST_RETRY_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    (!man_retry_q[1] && !wet_q[1]) |=> !man_retry_q[1])
    else $error("retry accepted without moisture");
  AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !done |=> $stable(reading_average_q) && $stable(final_current_code_q))
    else $error("results changed without completion");
  AST_SAMPLE_CNT: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_SAMPLE && $past(st_q) == ST_SAMPLE) |-> nsamp_q < samples_needed)
    else $error("sample count overrun");
  COV_DONE_WET: cover property (@(posedge hclk) disable iff (!hresetn) ev[EV_WET1]);
  COV_RETRY_SAT: cover property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_JUDGE && !done));
  COV_ABORT: cover property (@(posedge hclk) disable iff (!hresetn) ev[EV_ABORT]);

endmodule // contact_moisture_detector
`default_nettype wire

// ==== inc/moist_pkg.sv ====
`default_nettype none
package moist_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RETRY_CTRL = 8'h70;
  localparam logic [7:0] IDX_AVG_CTRL = 8'h72;
  localparam logic [7:0] IDX_NOISE = 8'h73;
  localparam logic [7:0] IDX_CUR_SEL = 8'h74;
  localparam logic [7:0] IDX_VTHRESH = 8'h75;
  localparam logic [7:0] IDX_CONTROL = 8'h76;
  localparam logic [7:0] IDX_FIN_CUR = 8'h78;
  localparam logic [7:0] IDX_AVG = 8'h79;
  localparam logic [7:0] IDX_MAX = 8'h7A;
  localparam logic [7:0] IDX_MIN = 8'h7B;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h7C;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h7D;
  // Control register field positions
  localparam int POS_AUTO_EN = 6;
  localparam int POS_MAN_CHECK = 4;
  localparam int POS_MAN_RETRY = 2;
  localparam int POS_REARM = 0;
  // Reset values
  localparam logic [5:0] RST_NOISE = 6'h00;
  localparam logic [1:0] RST_CUR_SEL = 2'h0;
  localparam logic [7:0] RST_VTHRESH = 8'h77;
  localparam logic [1:0] RST_REARM = 2'h3;
  localparam logic [2:0] RST_RETRY = 3'h1;
  localparam logic [2:0] RST_AVG_SEL = 3'h0;
  // Forced result codes
  localparam logic [1:0] CUR_FORCE_LOW = 2'b00;
  localparam logic [1:0] CUR_FORCE_SHORT = 2'b11;
  localparam logic [7:0] READ_LOW = 8'h00;
  localparam logic [7:0] READ_FULL = 8'hFF;
  // Interrupt status bits
  localparam int EV_DONE = 0;
  localparam int EV_WET1 = 1;
  localparam int EV_WET2 = 2;
  localparam int EV_ABORT = 3;
  localparam int EV_W = 4;
  // Timing of the automatic checks
  localparam longint CLK_HZ = 40_000_000;
  localparam longint AUTO_PERIOD_S = 16;
  localparam longint CH1_FIRST_S = 8;
  localparam longint CH2_FIRST_S = 16;
  localparam longint HALF_STEP_CYCLES = CH1_FIRST_S * CLK_HZ;
  // Measurement sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_JUDGE = 2'b10
  } meas_state_t;
endpackage
`default_nettype wire

// ==== verif/adc_front_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // From the detector
  input wire logic meas_active,
  // Sample pattern and pacing
  input wire logic [7:0] lo_val,
  input wire logic [7:0] hi_val,
  input wire logic [7:0] gap,
  // To the detector, and a strobe count for the test
  output logic adc_valid,
  output logic [7:0] adc_data,
  output logic [7:0] pulse_count
);
  logic [7:0] wait_q;
  logic [7:0] last_q;
  logic phase_q;
  logic act_q;
  // Alternating lo/hi samples, one strobe every gap+1 cycles (every two for a gap of zero) while active
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 8'h00;
      last_q <= 8'h00;
      phase_q <= 1'b0;
      act_q <= 1'b0;
      adc_valid <= 1'b0;
      pulse_count <= 8'h00;
    end else begin
      act_q <= meas_active;
      adc_valid <= 1'b0;
      if (meas_active && !act_q) begin
        pulse_count <= 8'h00;
        phase_q <= 1'b0;
        wait_q <= gap;
      end else if (meas_active) begin
        if (wait_q == 8'h00 && !adc_valid) begin
          adc_valid <= 1'b1;
          last_q <= phase_q ? hi_val : lo_val;
          phase_q <= ~phase_q;
          pulse_count <= pulse_count + 8'h01;
          wait_q <= gap;
        end else if (wait_q != 8'h00) begin
          wait_q <= wait_q - 8'h01;
        end
      end
    end
  end
  // Data is not held outside a strobe: show the inverse of the last sample
  assign adc_data = adc_valid ? last_q : ~last_q;
endmodule // adc_front_model
`default_nettype wire

// ==== verif/contact_moisture_detector_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module contact_moisture_detector_test;
  import moist_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, meas_active, meas_channel, irq;
  logic adc_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, pullup_code, moisture_found;
  logic [2:0] hsize;
  logic [7:0] adc_data, lo_val, hi_val, gap, pulse_count;
  logic hready;
  int err_count, n_checks;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  contact_moisture_detector #(.AUTO_HALF_CYCLES(50)) contact_moisture_detector_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas_active(meas_active),
    .meas_channel(meas_channel), .pullup_code(pullup_code), .adc_valid(adc_valid),
    .adc_data(adc_data), .moisture_found(moisture_found), .irq(irq));
  adc_front_model adc_front_model_i (
    .hclk(hclk), .hresetn(hresetn), .meas_active(meas_active), .lo_val(lo_val),
    .hi_val(hi_val), .gap(gap), .adc_valid(adc_valid), .adc_data(adc_data),
    .pulse_count(pulse_count));
  // Clock at 40 MHz
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Wait at an edge until the bus is ready, bounded
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1);
  endtask
  task automatic ahb_write(input logic [7:0] idx, input logic [31:0] d);
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    hsize <= 3'h2;
    hsel <= 1'b1;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
  endtask
  task automatic ahb_read(input logic [7:0] idx, output logic [31:0] d);
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hsel <= 1'b1;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    wait_ready();
    d = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  task automatic rd_check(input logic [7:0] idx, input logic [31:0] exp);
    ahb_read(idx, rd);
    check(rd, exp);
  endtask
  // Wait for a measurement to start and end, checking current step and channel
  task automatic run_meas(input logic [1:0] cur, input logic chan);
    int n;
    n = 0;
    while (meas_active !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    check({31'h0, meas_active}, 32'h1);
    check({30'h0, pullup_code}, {30'h0, cur});
    check({31'h0, meas_channel}, {31'h0, chan});
    n = 0;
    while (meas_active !== 1'b0 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    check({31'h0, meas_active}, 32'h0);
    repeat (2) @(posedge hclk);
  endtask
  task automatic results(input logic [7:0] fc, input logic [7:0] av, input logic [7:0] mx,
                         input logic [7:0] mn);
    rd_check(IDX_FIN_CUR, {24'h0, fc});
    rd_check(IDX_AVG, {24'h0, av});
    rd_check(IDX_MAX, {24'h0, mx});
    rd_check(IDX_MIN, {24'h0, mn});
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge hclk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    err_count = 0;
    n_checks = 0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    lo_val = 8'h40;
    hi_val = 8'h50;
    gap = 8'h04;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values; the noise margin is only read, never written
    rd_check(IDX_NOISE, 32'h0);
    rd_check(IDX_CUR_SEL, 32'h0);
    rd_check(IDX_VTHRESH, 32'h77);
    rd_check(IDX_CONTROL, 32'h03);
    rd_check(IDX_RETRY_CTRL, 32'h1);
    rd_check(IDX_AVG_CTRL, 32'h0);
    results(8'h00, 8'h00, 8'h00, 8'h00);
    rd_check(8'h50, 32'h0);
    ahb_write(IDX_AVG, 32'h5A);
    rd_check(IDX_AVG, 32'h0);
    // No measurement while automatic checks are off
    repeat (150) @(posedge hclk);
    check({31'h0, meas_active}, 32'h0);
    // Manual check on channel one, four samples, slow front end
    ahb_write(IDX_CONTROL, 32'h00);
    ahb_write(IDX_CUR_SEL, 32'h2);
    ahb_write(IDX_AVG_CTRL, 32'h2);
    ahb_write(IDX_IRQ_MASK, 32'h0F);
    ahb_write(IDX_CONTROL, 32'h10);
    rd_check(IDX_CONTROL, 32'h10);
    run_meas(2'h2, 1'b0);
    check({24'h0, pulse_count}, 32'h4);
    rd_check(IDX_CONTROL, 32'h00);
    results(8'h02, 8'h48, 8'h50, 8'h40);
    check({30'h0, moisture_found}, 32'h1);
    check({31'h0, irq}, 32'h1);
    rd_check(IDX_IRQ_STAT, 32'h3);
    ahb_write(IDX_IRQ_STAT, 32'h3);
    rd_check(IDX_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    ahb_write(IDX_IRQ_MASK, 32'h00);
    // Retry on a dry channel is refused, results stand
    ahb_write(IDX_CONTROL, 32'h08);
    rd_check(IDX_CONTROL, 32'h00);
    repeat (40) @(posedge hclk);
    rd_check(IDX_AVG, 32'h48);
    // Retry on the wet channel, prompt front end
    lo_val <= 8'h30;
    hi_val <= 8'h38;
    gap <= 8'h01;
    ahb_write(IDX_CONTROL, 32'h04);
    rd_check(IDX_CONTROL, 32'h04);
    run_meas(2'h2, 1'b0);
    rd_check(IDX_CONTROL, 32'h00);
    results(8'h02, 8'h34, 8'h38, 8'h30);
    // Open contact on channel two
    lo_val <= 8'hFF;
    hi_val <= 8'hFF;
    ahb_write(IDX_CUR_SEL, 32'h0);
    ahb_write(IDX_CONTROL, 32'h20);
    run_meas(2'h0, 1'b1);
    results(8'h00, 8'hFF, 8'hFF, 8'hFF);
    // Done and channel-one moisture still stand from the retry
    rd_check(IDX_IRQ_STAT, 32'h3);
    check({31'h0, irq}, 32'h0);
    // Short to ground on channel two
    lo_val <= 8'h00;
    hi_val <= 8'h00;
    ahb_write(IDX_CUR_SEL, 32'h3);
    ahb_write(IDX_CONTROL, 32'h20);
    run_meas(2'h3, 1'b1);
    results(8'h03, 8'h00, 8'h00, 8'h00);
    // Saturated reading persists after the retry: abort
    lo_val <= 8'h80;
    hi_val <= 8'hFF;
    ahb_write(IDX_IRQ_STAT, 32'hF);
    ahb_write(IDX_CUR_SEL, 32'h1);
    ahb_write(IDX_CONTROL, 32'h20);
    run_meas(2'h1, 1'b1);
    ahb_write(IDX_IRQ_MASK, 32'h08);
    rd_check(IDX_CONTROL, 32'h00);
    results(8'h00, 8'h00, 8'h00, 8'h00);
    rd_check(IDX_IRQ_STAT, 32'h9);
    check({31'h0, irq}, 32'h1);
    check({30'h0, moisture_found}, 32'h1);
    // Automatic check on channel one with re-arm; dry result clears the flag
    // Slow strobes so that no extra sample is offered before the block goes idle
    lo_val <= 8'h90;
    hi_val <= 8'h90;
    gap <= 8'h04;
    ahb_write(IDX_CUR_SEL, 32'h0);
    ahb_write(IDX_AVG_CTRL, 32'h0);
    ahb_write(IDX_CONTROL, 32'h41);
    run_meas(2'h0, 1'b0);
    check({24'h0, pulse_count}, 32'h1);
    check({30'h0, moisture_found}, 32'h0);
    results(8'h00, 8'h90, 8'h90, 8'h90);
    // Automatic check on channel two alone, served on its own slot
    ahb_write(IDX_RETRY_CTRL, 32'h0);
    rd_check(IDX_RETRY_CTRL, 32'h0);
    ahb_write(IDX_CONTROL, 32'h80);
    run_meas(2'h0, 1'b1);
    check({24'h0, pulse_count}, 32'h1);
    check({30'h0, moisture_found}, 32'h0);
    tally_and_finish();
  end
endmodule // contact_moisture_detector_test
`default_nettype wire
